// ==== rtl/timer3_pkg.sv ====
// Package: register map, field positions and counts for the timer block
package timer3_pkg;
   // ****************************************************
   // Register map
   // ****************************************************
   localparam logic [7:0] CTRL_ADDR = 8'h91;
   localparam logic [7:0] RELOAD_LO_ADDR = 8'h92;
   localparam logic [7:0] RELOAD_HI_ADDR = 8'h93;
   localparam logic [7:0] COUNT_LO_ADDR = 8'h94;
   localparam logic [7:0] COUNT_HI_ADDR = 8'h95;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   // ****************************************************
   // Control register fields
   // ****************************************************
   localparam int HIGH_OVF_BIT = 7;
   localparam int LOW_OVF_BIT = 6;
   localparam int LOW_IRQ_EN_BIT = 5;
   localparam int CAPTURE_EN_BIT = 4;
   localparam int SPLIT_BIT = 3;
   localparam int RUN_BIT = 2;
   localparam int UNUSED_BIT = 1;
   localparam int EXT_CLK_BIT = 0;
   // Bits software may write; the unused bit is masked off
   localparam logic [7:0] CTRL_WMASK = 8'hfd;
   // ****************************************************
   // Clock division
   // ****************************************************
   localparam int SYS_DIV = 12;
   localparam int EXT_DIV = 8;
   localparam logic [7:0] BYTE_MAX = 8'hff;
endpackage

// ==== rtl/tick_if.sv ====
// Interface: tick and edge events between the prescaler and the timer core
`timescale 1ns/1ps
interface tick_if;
   logic div12_tick;
   logic ext_tick;
   logic ext_fall;
   modport src (output div12_tick, output ext_tick, output ext_fall);
   modport dst (input div12_tick, input ext_tick, input ext_fall);
endinterface

// ==== rtl/timer3_prescale.sv ====
// Prescaler: system clock divided by 12 and external clock divided by 8
`timescale 1ns/1ps
module timer3_prescale (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // External oscillator, already synchronous to sys_clk
   input wire logic ext_osc,
   // Tick events
   tick_if.src ticks
);
   import timer3_pkg::*;

   logic [3:0] div12_r, div12_nxt;
   logic ext_prev_r, ext_prev_nxt;
   logic [2:0] div8_r, div8_nxt;

   // Next values for both dividers
   always_comb begin
      div12_nxt = (div12_r == 4'(SYS_DIV - 1)) ? 4'h0 : div12_r + 4'h1;
      ext_prev_nxt = ext_osc;
      div8_nxt = div8_r;
      if (ext_osc && !ext_prev_r) begin
         div8_nxt = div8_r + 3'h1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         div12_r <= 4'h0;
         ext_prev_r <= 1'b0;
         div8_r <= 3'h0;
      end else begin
         div12_r <= div12_nxt;
         ext_prev_r <= ext_prev_nxt;
         div8_r <= div8_nxt;
      end
   end

   // One tick per period of each derived clock
   assign ticks.div12_tick = (div12_r == 4'(SYS_DIV - 1));
   // Divided clock rises when the counter wraps back to zero
   assign ticks.ext_tick = ext_osc && !ext_prev_r && (div8_r == 3'h7);
   // Falling edge of the divided clock: counter reaches half way
   assign ticks.ext_fall = ext_osc && !ext_prev_r &&
      (div8_r == 3'(EXT_DIV / 2 - 1));
endmodule // timer3_prescale

// ==== rtl/timer3_core.sv ====
// Timer 3: control register, counter, reload and overflow flags
`timescale 1ns/1ps
module timer3_core (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // Special function register bus
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_wr,
   output logic [7:0] sfr_rdata,
   // Clock sources and per-byte selects from the clock control register
   input wire logic ext_osc,
   input wire logic upper_byte_clock_select,
   input wire logic lower_byte_clock_select,
   // Interrupt enable from the interrupt controller
   input wire logic timer_irq_enable,
   // Interrupt request while timer_irq_enable is set, one pulse per cycle in which the high flag, or the low flag with its enable set, newly sets
   output logic timer_irq
);
   import timer3_pkg::*;

   tick_if ticks ();

   timer3_prescale u_prescale (
      .sys_clk(sys_clk),
      .reset(reset),
      .ext_osc(ext_osc),
      .ticks(ticks)
   );

   // ****************************************************
   // State
   // ****************************************************
   logic [7:0] ctrl_r, ctrl_nxt;
   logic [7:0] count_lo_r, count_lo_nxt;
   logic [7:0] count_hi_r, count_hi_nxt;
   logic [7:0] reload_lo_r, reload_lo_nxt;
   logic [7:0] reload_hi_r, reload_hi_nxt;
   logic [7:0] rdata_nxt;
   logic irq_nxt;

   logic high_flag, low_flag, low_irq_en, capture_en, split, run, ext_sel;
   logic derived_tick, lo_tick, hi_tick, lo_inc, hi_inc;
   logic lo_wrap, hi_wrap, full_wrap, capture_evt;
   logic set_high, set_low, wr_ctrl;
   logic [7:0] ctrl_written;

   assign high_flag = ctrl_r[HIGH_OVF_BIT];
   assign low_flag = ctrl_r[LOW_OVF_BIT];
   assign low_irq_en = ctrl_r[LOW_IRQ_EN_BIT];
   assign capture_en = ctrl_r[CAPTURE_EN_BIT];
   assign split = ctrl_r[SPLIT_BIT];
   assign run = ctrl_r[RUN_BIT];
   assign ext_sel = ctrl_r[EXT_CLK_BIT];

   // ****************************************************
   // Clock selection and count enables
   // ****************************************************
   // Derived clock is shared by both bytes, the byte select overrides
   assign derived_tick = ext_sel ? ticks.ext_tick : ticks.div12_tick;
   assign lo_tick = lower_byte_clock_select ? 1'b1 : derived_tick;
   assign hi_tick = upper_byte_clock_select ? 1'b1 : derived_tick;
   // Lower byte free-runs in split mode; 16-bit mode needs run control
   assign lo_inc = lo_tick && (split || run);
   assign hi_inc = split ? (hi_tick && run) : 1'b0;
   assign lo_wrap = lo_inc && (count_lo_r == BYTE_MAX);
   // 16-bit wrap only when both bytes are at their maximum
   assign full_wrap = !split && lo_wrap && (count_hi_r == BYTE_MAX);
   assign hi_wrap = split ? (hi_inc && count_hi_r == BYTE_MAX)
                          : full_wrap;
   // Capture is timed by the divided external clock alone
   assign capture_evt = capture_en && ticks.ext_fall;
   assign set_high = hi_wrap || capture_evt;
   assign set_low = lo_wrap;
   assign wr_ctrl = sfr_wr && (sfr_addr == CTRL_ADDR);
   assign ctrl_written = sfr_wdata & CTRL_WMASK;

   // ****************************************************
   // Next-state logic
   // ****************************************************
   // Hardware set is ORed after the software write so a set never loses
   always_comb begin
      ctrl_nxt = ctrl_r;
      if (wr_ctrl) begin
         ctrl_nxt = ctrl_written;
      end
      if (set_high) begin
         ctrl_nxt[HIGH_OVF_BIT] = 1'b1;
      end
      if (set_low) begin
         ctrl_nxt[LOW_OVF_BIT] = 1'b1;
      end

      count_lo_nxt = count_lo_r;
      count_hi_nxt = count_hi_r;
      if (full_wrap) begin
         count_lo_nxt = reload_lo_r;
         count_hi_nxt = reload_hi_r;
      end else if (split) begin
         if (lo_wrap) begin
            count_lo_nxt = reload_lo_r;
         end else if (lo_inc) begin
            count_lo_nxt = count_lo_r + 8'h01;
         end
         if (hi_inc && count_hi_r == BYTE_MAX) begin
            count_hi_nxt = reload_hi_r;
         end else if (hi_inc) begin
            count_hi_nxt = count_hi_r + 8'h01;
         end
      end else if (lo_inc) begin
         count_lo_nxt = count_lo_r + 8'h01;
         if (lo_wrap) begin
            count_hi_nxt = count_hi_r + 8'h01;
         end
      end
      // Counter writes from software take precedence over counting
      if (sfr_wr && sfr_addr == COUNT_LO_ADDR) begin
         count_lo_nxt = sfr_wdata;
      end
      if (sfr_wr && sfr_addr == COUNT_HI_ADDR) begin
         count_hi_nxt = sfr_wdata;
      end

      reload_lo_nxt = reload_lo_r;
      reload_hi_nxt = reload_hi_r;
      if (sfr_wr && sfr_addr == RELOAD_LO_ADDR) begin
         reload_lo_nxt = sfr_wdata;
      end
      if (sfr_wr && sfr_addr == RELOAD_HI_ADDR) begin
         reload_hi_nxt = sfr_wdata;
      end
      // Capture wins over a software write in the same cycle
      if (capture_evt) begin
         reload_lo_nxt = count_lo_r;
         reload_hi_nxt = count_hi_r;
      end

      // Read mux; unmapped addresses read zero
      case (sfr_addr)
         CTRL_ADDR: rdata_nxt = ctrl_r;
         RELOAD_LO_ADDR: rdata_nxt = reload_lo_r;
         RELOAD_HI_ADDR: rdata_nxt = reload_hi_r;
         COUNT_LO_ADDR: rdata_nxt = count_lo_r;
         COUNT_HI_ADDR: rdata_nxt = count_hi_r;
         default: rdata_nxt = 8'h00;
      endcase

      // With timer_irq_enable set, request on a rising high flag, or a rising low flag with its enable set, whether hardware or software set it
      irq_nxt = timer_irq_enable &&
         ((ctrl_nxt[HIGH_OVF_BIT] && !high_flag) ||
          (low_irq_en && ctrl_nxt[LOW_OVF_BIT] && !low_flag));
   end

   // ****************************************************
   // Registers
   // ****************************************************
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         ctrl_r <= CTRL_RESET;
         count_lo_r <= BYTE_RESET;
         count_hi_r <= BYTE_RESET;
         reload_lo_r <= BYTE_RESET;
         reload_hi_r <= BYTE_RESET;
         sfr_rdata <= 8'h00;
         timer_irq <= 1'b0;
      end else begin
         ctrl_r <= ctrl_nxt;
         count_lo_r <= count_lo_nxt;
         count_hi_r <= count_hi_nxt;
         reload_lo_r <= reload_lo_nxt;
         reload_hi_r <= reload_hi_nxt;
         sfr_rdata <= rdata_nxt;
         timer_irq <= irq_nxt;
      end
   end
endmodule // timer3_core

// ==== tb/timer3_core_sva.sv ====
// Checker: port timing assertions for the timer core
`timescale 1ns/1ps
module timer3_core_sva (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // Register bus and interrupt
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_rdata,
   input wire logic timer_irq_enable,
   input wire logic timer_irq
);
   import timer3_pkg::*;
   // ****************************************************
   // Assertions
   // ****************************************************
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (reset);
   // Read data lags the address by one cycle, so most checks look back
   property p_irq_pulse;
      timer_irq |=> !timer_irq;
   endproperty
   a_irq_pulse: assert property (p_irq_pulse) else $error("long irq");
   property p_irq_cause;
      timer_irq |-> $past(timer_irq_enable);
   endproperty
   a_irq_cause: assert property (p_irq_cause) else $error("irq off");
   property p_flag_irq;
      $past(sfr_addr) == CTRL_ADDR && $past(sfr_addr, 2) == CTRL_ADDR &&
      $rose(sfr_rdata[HIGH_OVF_BIT]) && timer_irq_enable |->
      (timer_irq || $past(timer_irq)) or (##1 timer_irq);
   endproperty
   a_flag_irq: assert property (p_flag_irq) else $error("no irq");
   property p_ctrl_write;
      sfr_wr && sfr_addr == CTRL_ADDR ##1 sfr_addr == CTRL_ADDR |=>
      (sfr_rdata & 8'h3d) == ($past(sfr_wdata, 2) & 8'h3d);
   endproperty
   a_ctrl_write: assert property (p_ctrl_write) else $error("ctrl");
   property p_flag_sticky;
      $past(sfr_addr) == CTRL_ADDR && sfr_addr == CTRL_ADDR &&
      !$past(sfr_wr) |=>
      (sfr_rdata[7:6] & $past(sfr_rdata[7:6])) == $past(sfr_rdata[7:6]);
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) else $error("flag");
   property p_unused_zero;
      $past(sfr_addr) == CTRL_ADDR |-> !sfr_rdata[UNUSED_BIT];
   endproperty
   a_unused_zero: assert property (p_unused_zero) else $error("bit1");
   property p_unmapped;
      !($past(sfr_addr) inside {[CTRL_ADDR:COUNT_HI_ADDR]}) |-> !sfr_rdata;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped");
   property p_reset_clear;
      $fell(reset) |-> sfr_rdata == 8'h00 && !timer_irq;
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("reset");
   // Main scenarios reached
   c_irq: cover property (timer_irq);
   c_flag: cover property ($rose(sfr_rdata[HIGH_OVF_BIT]));
   c_write: cover property (sfr_wr && sfr_addr == CTRL_ADDR);
endmodule // timer3_core_sva
bind timer3_core timer3_core_sva timer3_core_sva_i (.sys_clk(sys_clk),
   .reset(reset), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
   .sfr_wr(sfr_wr), .sfr_rdata(sfr_rdata),
   .timer_irq_enable(timer_irq_enable), .timer_irq(timer_irq));

// ==== tb/tb.sv ====
// Testbench: registers, flags, interrupt and count rates of the timer
`timescale 1ns/1ps
module tb;
   import timer3_pkg::*;
   logic sys_clk, reset, sfr_wr, ext_osc, ub_sel, lb_sel, irq_en, seen;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, v, a;
   logic timer_irq;
   int fails, num_checks;
   // Rows: address, write data, expected read back
   logic [23:0] rows [9] = '{24'h910200, 24'h912929, 24'h910000,
      24'h925a5a, 24'h93a5a5, 24'h941212, 24'h953434, 24'h907700,
      24'h967700};
   timer3_core timer3_core_i (.sys_clk(sys_clk), .reset(reset),
      .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
      .sfr_rdata(sfr_rdata), .ext_osc(ext_osc),
      .upper_byte_clock_select(ub_sel), .lower_byte_clock_select(lb_sel),
      .timer_irq_enable(irq_en), .timer_irq(timer_irq));
   // ****************************************************
   // Clock, oscillator and pulse catcher
   // ****************************************************
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   // Oscillator at half the clock; divided tick every 16 cycles
   always @(posedge sys_clk) ext_osc <= #1 ~ext_osc;
   // Pulses last one cycle, so latch them for polling code
   always @(posedge sys_clk) if (timer_irq === 1'b1) seen <= 1'b1;
   // ****************************************************
   // Tasks
   // ****************************************************
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic check(input string what, input logic [7:0] got, exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] ad, d);
      sfr_addr = ad;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      tick(1);
      sfr_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] ad);
      sfr_addr = ad;
      tick(1);
      v = sfr_rdata;
   endtask
   // Bounded poll; always reads first so a stale value never satisfies it
   task automatic wait_flag(input int b);
      int k;
      k = 0;
      do begin
         rd(CTRL_ADDR);
         k++;
      end while (k < 400 && v[b] !== 1'b1);
      if (v[b] !== 1'b1) begin
         fails++;
         conclude();
      end
   endtask
   task automatic conclude();
      if (fails == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // ****************************************************
   // Main sequence
   // ****************************************************
   initial begin
      {reset, sfr_addr, sfr_wdata, sfr_wr, ub_sel, lb_sel, irq_en} = '1;
      {sfr_addr, sfr_wdata, sfr_wr, ext_osc, ub_sel, lb_sel, irq_en} = '0;
      {fails, num_checks, seen, v} = '0;
      tick(6);
      reset = 1'b0;
      for (int i = 0; i < 5; i++) begin
         rd(CTRL_ADDR + 8'(i));
         check("reset value", v, 8'h00);
      end
      foreach (rows[i]) begin
         wr(rows[i][23:16], rows[i][15:8]);
         rd(rows[i][23:16]);
         check("register", v, rows[i][7:0]);
      end
      // Full 16-bit wrap: both flags, reload, interrupt
      {irq_en, lb_sel, ub_sel} = 3'b111;
      wr(COUNT_LO_ADDR, 8'hf0);
      wr(COUNT_HI_ADDR, 8'hff);
      wr(CTRL_ADDR, 8'h04);
      wait_flag(HIGH_OVF_BIT);
      check("wrap flags", v, 8'hc4);
      rd(COUNT_HI_ADDR);
      check("reload", v, 8'ha5);
      check("wrap irq", {7'h0, seen}, 8'h01);
      tick(40);
      rd(CTRL_ADDR);
      check("sticky", v, 8'hc4);
      // Low byte interrupt only with its enable set
      for (int e = 0; e < 2; e++) begin
         wr(CTRL_ADDR, 8'h00);
         wr(COUNT_LO_ADDR, 8'hf0);
         seen = 1'b0;
         wr(CTRL_ADDR, e ? 8'h24 : 8'h04);
         wait_flag(LOW_OVF_BIT);
         check("low wrap", v, e ? 8'h64 : 8'h44);
         tick(2);
         check("low irq", {7'h0, seen}, 8'(e));
      end
      // Split, stopped: low byte runs, upper byte holds
      wr(CTRL_ADDR, 8'h00);
      wr(COUNT_HI_ADDR, 8'h80);
      wr(CTRL_ADDR, 8'h08);
      wait_flag(LOW_OVF_BIT);
      check("split flags", v, 8'h48);
      rd(COUNT_HI_ADDR);
      check("upper held", v, 8'h80);
      // Split, running: upper byte on undivided clock counts every cycle
      wr(CTRL_ADDR, 8'h0c);
      rd(COUNT_HI_ADDR);
      a = v;
      tick(9);
      rd(COUNT_HI_ADDR);
      check("upper rate", v - a, 8'h0a);
      // Divided rates: ten ticks in 120 and in 160 cycles
      lb_sel = 1'b0;
      for (int m = 0; m < 2; m++) begin
         wr(COUNT_LO_ADDR, 8'h00);
         wr(CTRL_ADDR, 8'h04 | 8'(m));
         rd(COUNT_LO_ADDR);
         a = v;
         tick(m ? 159 : 119);
         rd(COUNT_LO_ADDR);
         check("divided rate", v - a, 8'h0a);
      end
      // Software set of the high flag counts as an event
      for (int e = 0; e < 2; e++) begin
         irq_en = e[0];
         wr(CTRL_ADDR, 8'h00);
         seen = 1'b0;
         wr(CTRL_ADDR, 8'h80);
         tick(3);
         check("soft set irq", {7'h0, seen}, 8'(e));
      end
      // Capture copies the count into the reload pair
      lb_sel = 1'b1;
      wr(CTRL_ADDR, 8'h00);
      wr(COUNT_LO_ADDR, 8'h00);
      wr(COUNT_HI_ADDR, 8'h00);
      wr(CTRL_ADDR, 8'h14);
      wait_flag(HIGH_OVF_BIT);
      rd(RELOAD_HI_ADDR);
      check("capture", v, 8'h00);
      reset = 1'b1;
      tick(2);
      reset = 1'b0;
      rd(CTRL_ADDR);
      check("second reset", v, 8'h00);
      conclude();
   end
endmodule // tb
